/* verilog/prom_word_programmer_map.svh */
`ifndef PROM_WORD_PROGRAMMER_MAP_SVH
`define PROM_WORD_PROGRAMMER_MAP_SVH

`define CLOCK_MHZ 25
`define ZERO_PULSE_NS 400
`define ONE_PULSE_MS 20
`define HOLD_MS 5
`define ZERO_PULSE_CYC ((`ZERO_PULSE_NS * `CLOCK_MHZ + 999) / 1000)
`define ONE_PULSE_CYC (`ONE_PULSE_MS * 1000 * `CLOCK_MHZ)
`define HOLD_CYC (`HOLD_MS * 1000 * `CLOCK_MHZ)
// Accumulator bit 0 is the most significant: bits 4-15 sit in acc[11:0]
`define ADDR_LSB 0
`define ADDR_MSB 11
// Mask bit 12 of the accumulator word, counted the same way
`define MASK_BIT_POS 3
`define WORD_BITS 16
`define BANK_SEL_512 8
`define BANK_SEL_256 9

`endif

/* verilog/prom_word_programmer_pkg.sv */
`default_nettype none
package prom_word_programmer_pkg;
  typedef enum logic [2:0] {flag_none, flag_start, flag_clear, flag_pulse} flag_cmd_t;
  typedef struct packed {
    logic output_a_cmd;
    logic output_b_cmd;
    logic input_a_cmd;
    logic mask_out_cmd;
    logic io_reset_cmd;
    flag_cmd_t flag;
    logic [15:0] acc;
  } io_cmd_t;
  typedef enum logic [1:0] {st_idle, st_pulse, st_hold} burn_state_t;
endpackage
`default_nettype wire

/* verilog/pulse_timer.sv */
`include "prom_word_programmer_map.svh"
`default_nettype none
module pulse_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic expired
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic run_q;
  logic run_d;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (load)
    begin
      cnt_d = count;
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q <= WIDTH'(1))
        run_d = 1'b0;
      else
        cnt_d = cnt_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  // Pulses once on the last counted cycle
  // Load kept out of this term: the sequencer reloads on expiry
  assign expired = run_q && (cnt_q <= WIDTH'(1));
endmodule
`default_nettype wire

/* verilog/prom_word_programmer.sv */
`include "prom_word_programmer_map.svh"
`default_nettype none
module prom_word_programmer #(
  parameter int ONE_PULSE_CYCLES = `ONE_PULSE_CYC,
  parameter int HOLD_CYCLES = `HOLD_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire prom_word_programmer_pkg::io_cmd_t cmd,
  input wire logic bank_256,
  input wire logic [15:0] board_data,
  output logic [15:0] readback_word,
  output logic readback_valid,
  output logic busy,
  output logic done,
  output logic int_req,
  output logic [11:0] board_address,
  output logic [7:0] bank_enable,
  output logic [15:0] relay_drive
);
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [11:0] burn_address_q;
  logic [11:0] burn_address_d;
  logic [15:0] burn_data_buffer_q;
  logic [15:0] burn_data_buffer_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic mask_q;
  logic mask_d;
  logic int_q;
  logic int_d;
  logic [15:0] rb_q;
  logic [15:0] rb_d;
  logic rbv_q;
  logic rbv_d;

  // ---------------------------------------------
  // Sequencer state
  // ---------------------------------------------
  prom_word_programmer_pkg::burn_state_t state_q;
  prom_word_programmer_pkg::burn_state_t state_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] bank_q;
  logic [7:0] bank_d;
  logic [11:0] addr_out_q;
  logic [11:0] addr_out_d;
  logic [15:0] relay_q;
  logic [15:0] relay_d;
  logic tmr_load;
  logic [31:0] tmr_count;
  logic tmr_expired;
  logic start;
  logic finish;

  assign start = (cmd.flag == prom_word_programmer_pkg::flag_start) && !cmd.io_reset_cmd;

  pulse_timer #(.WIDTH(32)) timer_i (
    .clock(clock),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  always_comb
  begin
    state_d = state_q;
    bit_d = bit_q;
    bank_d = bank_q;
    addr_out_d = addr_out_q;
    relay_d = '0;
    tmr_load = 1'b0;
    tmr_count = 32'(`ZERO_PULSE_CYC);
    finish = 1'b0;
    unique case (state_q)
      prom_word_programmer_pkg::st_idle:
      begin
        bank_d = '0;
        if (start)
        begin
          // Latched values used; a load in the same command lands first
          addr_out_d = burn_address_d;
          // Bank size picks which three of the top four bits select the bank
          bank_d = bank_256 ? 8'(8'h01 << burn_address_d[10:8]) : 8'(8'h01 << burn_address_d[11:9]);
          bit_d = 4'h0;
          relay_d = 16'h8000;
          tmr_load = 1'b1;
          tmr_count = burn_data_buffer_d[15] ? 32'(ONE_PULSE_CYCLES) : 32'(`ZERO_PULSE_CYC);
          state_d = prom_word_programmer_pkg::st_pulse;
        end
      end
      prom_word_programmer_pkg::st_pulse:
      begin
        relay_d = 16'(16'h8000 >> bit_q);
        if (tmr_expired)
        begin
          tmr_load = 1'b1;
          if (bit_q == 4'hf)
          begin
            relay_d = '0;
            bank_d = '0;
            tmr_count = 32'(HOLD_CYCLES);
            state_d = prom_word_programmer_pkg::st_hold;
          end
          else
          begin
            bit_d = bit_q + 4'h1;
            // Next relay rises on the same edge, so each pulse spans its whole count
            relay_d = 16'(16'h8000 >> bit_d);
            tmr_count = burn_data_buffer_q[14] ? 32'(ONE_PULSE_CYCLES) : 32'(`ZERO_PULSE_CYC);
          end
        end
      end
      prom_word_programmer_pkg::st_hold:
      begin
        if (tmr_expired)
          state_d = prom_word_programmer_pkg::st_idle;
      end
      default:
        state_d = prom_word_programmer_pkg::st_idle;
    endcase
    // Clear or reset aborts the cycle and drops the relays
    if (cmd.io_reset_cmd || (cmd.flag == prom_word_programmer_pkg::flag_clear))
    begin
      state_d = prom_word_programmer_pkg::st_idle;
      bank_d = '0;
      relay_d = '0;
    end
    finish = (state_q == prom_word_programmer_pkg::st_pulse) && tmr_expired && (bit_q == 4'hf)
      && (state_d == prom_word_programmer_pkg::st_hold);
  end

  // ---------------------------------------------
  // Register and flag updates
  // ---------------------------------------------
  always_comb
  begin
    burn_address_d = burn_address_q;
    burn_data_buffer_d = burn_data_buffer_q;
    busy_d = busy_q;
    done_d = done_q;
    mask_d = mask_q;
    rb_d = rb_q;
    rbv_d = 1'b0;
    if (cmd.output_b_cmd)
      burn_address_d = cmd.acc[`ADDR_MSB:`ADDR_LSB];
    if (cmd.output_a_cmd)
      burn_data_buffer_d = cmd.acc;
    if (state_q == prom_word_programmer_pkg::st_pulse && tmr_expired)
      burn_data_buffer_d = {burn_data_buffer_q[14:0], 1'b0};
    if (cmd.input_a_cmd)
    begin
      // Board lines are captured into rb_q here and held there until the next read
      rb_d = board_data;
      rbv_d = 1'b1;
    end
    if (cmd.mask_out_cmd)
      mask_d = cmd.acc[`MASK_BIT_POS];
    if (finish)
    begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
    unique case (cmd.flag)
      prom_word_programmer_pkg::flag_start:
      begin
        busy_d = 1'b1;
        done_d = 1'b0;
      end
      prom_word_programmer_pkg::flag_clear:
      begin
        busy_d = 1'b0;
        done_d = 1'b0;
      end
      prom_word_programmer_pkg::flag_pulse:
        done_d = finish;
      default:
      begin
      end
    endcase
    if (cmd.io_reset_cmd)
    begin
      busy_d = 1'b0;
      done_d = 1'b0;
    end
    int_d = done_d && !mask_d;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burn_address_q <= '0;
      burn_data_buffer_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      mask_q <= 1'b0;
      int_q <= 1'b0;
      rb_q <= '0;
      rbv_q <= 1'b0;
      state_q <= prom_word_programmer_pkg::st_idle;
      bit_q <= '0;
      bank_q <= '0;
      addr_out_q <= '0;
      relay_q <= '0;
    end
    else
    begin
      burn_address_q <= burn_address_d;
      burn_data_buffer_q <= burn_data_buffer_d;
      busy_q <= busy_d;
      done_q <= done_d;
      mask_q <= mask_d;
      int_q <= int_d;
      rb_q <= rb_d;
      rbv_q <= rbv_d;
      state_q <= state_d;
      bit_q <= bit_d;
      bank_q <= bank_d;
      addr_out_q <= addr_out_d;
      relay_q <= relay_d;
    end
  end

  assign readback_word = rb_q;
  assign readback_valid = rbv_q;
  assign busy = busy_q;
  assign done = done_q;
  assign int_req = int_q;
  assign board_address = addr_out_q;
  assign bank_enable = bank_q;
  assign relay_drive = relay_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  sequence s_start_cmd;
    cmd.flag == prom_word_programmer_pkg::flag_start && !cmd.io_reset_cmd;
  endsequence

  sequence s_idle_start;
    s_start_cmd and (state_q == prom_word_programmer_pkg::st_idle);
  endsequence

  sequence s_zero_relay;
    (relay_drive == 16'h8000) [*8] ##1 (relay_drive == 16'h8000) [*2] ##1 (relay_drive != 16'h8000);
  endsequence

  AST_START_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    s_start_cmd |=> busy && !done) else $error("start did not set busy");
  AST_CLEAR_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.flag == prom_word_programmer_pkg::flag_clear |=> !busy && !done) else $error("clear left a flag");
  AST_PULSE_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.flag == prom_word_programmer_pkg::flag_pulse && !cmd.io_reset_cmd && !finish
    |=> !done && busy == $past(busy)) else $error("pulse changed busy");
  AST_RESET_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.io_reset_cmd |=> !busy && !done) else $error("io reset left a flag");
  AST_ADDR_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.output_b_cmd |=> burn_address_q == $past(cmd.acc[11:0])) else $error("address not loaded");
  AST_DATA_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.output_a_cmd && !(state_q == prom_word_programmer_pkg::st_pulse && tmr_expired)
    |=> burn_data_buffer_q == $past(cmd.acc)) else $error("data not loaded");
  // Clear or reset may legally cut the pulse short
  AST_ZERO_PULSE: assert property (@(posedge clock)
    disable iff (!rst_n || cmd.io_reset_cmd || cmd.flag == prom_word_programmer_pkg::flag_clear)
    (s_idle_start and !burn_data_buffer_d[15]) |=> s_zero_relay) else $error("zero pulse length wrong");
  AST_FINISH_DONE: assert property (@(posedge clock) disable iff (!rst_n)
    finish && cmd.flag != prom_word_programmer_pkg::flag_start |=> done && !busy) else $error("completion flags wrong");
  AST_INT_MASK: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.mask_out_cmd && cmd.acc[`MASK_BIT_POS] |=> !int_req) else $error("interrupt not masked");
  AST_INT_RAISE: assert property (@(posedge clock) disable iff (!rst_n)
    finish && !mask_q && !cmd.mask_out_cmd && cmd.flag != prom_word_programmer_pkg::flag_start
    |=> int_req) else $error("no interrupt on done");
  AST_ADDR_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == prom_word_programmer_pkg::st_pulse && $past(state_q) == prom_word_programmer_pkg::st_pulse
    |-> $stable(board_address)) else $error("address moved mid cycle");
  AST_BANK_ONEHOT: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == prom_word_programmer_pkg::st_pulse |-> $onehot(bank_enable)) else $error("bank not one-hot");
  AST_RELAY_BIT: assert property (@(posedge clock) disable iff (!rst_n)
    relay_drive != 16'h0000 |-> $onehot(relay_drive)) else $error("more than one relay");
  AST_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.input_a_cmd |=> readback_valid && readback_word == $past(board_data)) else $error("readback wrong");
  AST_BIT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    $past(relay_drive) != 16'h0000 && relay_drive != 16'h0000 && relay_drive != $past(relay_drive)
    |-> relay_drive == ($past(relay_drive) >> 1)) else $error("relay order broken");
  AST_HOLD_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == prom_word_programmer_pkg::st_hold && $past(state_q) == prom_word_programmer_pkg::st_hold
    |-> $stable(board_address) && relay_drive == 16'h0000) else $error("hold phase not quiet");
  AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == prom_word_programmer_pkg::st_idle |-> relay_drive == 16'h0000 && bank_enable == 8'h00)
    else $error("relays live while idle");
  AST_START_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    s_idle_start |=> board_address == burn_address_q) else $error("board address not latched");
  AST_BANK_SEL: assert property (@(posedge clock) disable iff (!rst_n)
    s_idle_start |=> bank_enable == 8'(8'h01 << ($past(bank_256) ? board_address[10:8] : board_address[11:9])))
    else $error("wrong bank enabled");
endmodule
`default_nettype wire

/* sim/host_model.sv */
`default_nettype none
module host_model (
  input wire logic clock,
  output var prom_word_programmer_pkg::io_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd = '0;
  // ----------------------------------------
  // Command strobes
  // ----------------------------------------
  // One strobe per call; an idle edge always follows it
  task automatic send(input logic [4:0] kind, input prom_word_programmer_pkg::flag_cmd_t f, input logic [15:0] acc);
    @(posedge clock);
    cmd <= {kind, f, acc};
    @(posedge clock);
    cmd <= '0;
  endtask
  task automatic load_go(input logic [15:0] addr, input logic [15:0] data, input logic data_first);
    if (data_first)
    begin
      send(5'h10, prom_word_programmer_pkg::flag_none, data);
      send(5'h08, prom_word_programmer_pkg::flag_start, addr);
    end
    else
    begin
      send(5'h08, prom_word_programmer_pkg::flag_none, addr);
      send(5'h10, prom_word_programmer_pkg::flag_start, data);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_prom_word_programmer.sv */
`default_nettype none
module tb_prom_word_programmer;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run brief
  localparam int ONE = 40;
  localparam int HOLD = 30;
  typedef struct {logic [15:0] acc; logic [15:0] data; logic b256; logic dfirst; logic [11:0] ea; logic [7:0] eb;} row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bank_256 = 1'b0;
  logic [15:0] board_data = 16'h0000;
  prom_word_programmer_pkg::io_cmd_t cmd;
  logic [15:0] readback_word;
  logic [15:0] relay_drive;
  logic readback_valid, busy, done, int_req;
  logic [11:0] board_address;
  logic [7:0] bank_enable;
  int err_total = 0;
  int comparisons = 0;
  row_t rows [3] = '{'{16'hfff5, 16'h8001, 1'b0, 1'b0, 12'hff5, 8'h80},
    '{16'h1230, 16'h0000, 1'b1, 1'b1, 12'h230, 8'h04},
    '{16'h5a0f, 16'h4002, 1'b0, 1'b0, 12'ha0f, 8'h20}};
  prom_word_programmer #(.ONE_PULSE_CYCLES(ONE), .HOLD_CYCLES(HOLD)) u_dut (.clock(clock), .rst_n(rst_n),
    .cmd(cmd), .bank_256(bank_256), .board_data(board_data), .readback_word(readback_word),
    .readback_valid(readback_valid), .busy(busy), .done(done), .int_req(int_req),
    .board_address(board_address), .bank_enable(bank_enable), .relay_drive(relay_drive));
  host_model u_host (.clock(clock), .cmd(cmd));
  initial forever #20 clock = ~clock;
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic flags(input logic eb, input logic ed);
    chk("busy", {15'h0, eb}, {15'h0, busy});
    chk("done", {15'h0, ed}, {15'h0, done});
  endtask
  // ----------------------------------------
  // One full burn and read-back
  // ----------------------------------------
  task automatic burn(input row_t r, input logic eint);
    int n;
    @(posedge clock);
    bank_256 <= r.b256;
    u_host.load_go(r.acc, r.data, r.dfirst);
    @(negedge clock);
    flags(1'b1, 1'b0);
    chk("board_address", {4'h0, r.ea}, {4'h0, board_address});
    chk("bank_enable", {8'h0, r.eb}, {8'h0, bank_enable});
    for (int b = 15; b >= 0; b--)
    begin
      n = 0;
      while (relay_drive !== (16'h1 << b) && n < 4)
      begin
        n++;
        @(negedge clock);
      end
      n = 0;
      while (relay_drive === (16'h1 << b) && n < 200)
      begin
        n++;
        @(negedge clock);
      end
      if (r.data[b])
        chk("relay_one_len", 16'(ONE), n[15:0]);
      else
        chk("relay_zero_len", 16'h000a, n[15:0]);
    end
    n = 0;
    while (done !== 1'b1 && n < 4)
    begin
      n++;
      @(negedge clock);
    end
    flags(1'b0, 1'b1);
    chk("int_req", {15'h0, eint}, {15'h0, int_req});
    chk("held_address", {4'h0, r.ea}, {4'h0, board_address});
    board_data <= r.data;
    // Read back well inside the hold window
    u_host.send(5'h04, prom_word_programmer_pkg::flag_none, 16'h0000);
    board_data <= ~r.data;
    @(negedge clock);
    chk("readback_valid", 16'h1, {15'h0, readback_valid});
    chk("readback_word", r.data, readback_word);
    repeat (HOLD + 4) @(negedge clock);
  endtask
  initial
  begin
    #(40 * 20000);
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    flags(1'b0, 1'b0);
    chk("relay_in_reset", 16'h0000, relay_drive);
    @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i])
      burn(rows[i], 1'b1);
    u_host.send(5'h00, prom_word_programmer_pkg::flag_pulse, 16'h0000);
    @(negedge clock);
    flags(1'b0, 1'b0);
    chk("int_after_pulse", 16'h0, {15'h0, int_req});
    u_host.load_go(16'h0010, 16'hffff, 1'b0);
    repeat (5) @(negedge clock);
    u_host.send(5'h00, prom_word_programmer_pkg::flag_pulse, 16'h0000);
    @(negedge clock);
    flags(1'b1, 1'b0);
    u_host.send(5'h00, prom_word_programmer_pkg::flag_clear, 16'h0000);
    @(negedge clock);
    flags(1'b0, 1'b0);
    repeat (HOLD + 4) @(negedge clock);
    u_host.send(5'h02, prom_word_programmer_pkg::flag_none, 16'h0008);
    burn(rows[1], 1'b0);
    u_host.send(5'h02, prom_word_programmer_pkg::flag_none, 16'h0000);
    @(negedge clock);
    chk("int_unmasked", 16'h1, {15'h0, int_req});
    u_host.send(5'h01, prom_word_programmer_pkg::flag_none, 16'h0000);
    @(negedge clock);
    flags(1'b0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
